// >>> frp_read_path.v
// Two-port FIFO with mailboxes and port B parity, swap and bus-size read path
//
// The implementer's own choices: the address map and the Avalon-MM interface to the registers.
`default_nettype none
`include "frp_defs.vh"
module frp_read_path (
	input  wire        ref_clk_i,
	input  wire        rst_i,
	input  wire [3:0]  avs_address_i,
	input  wire        avs_read_i,
	input  wire        avs_write_i,
	input  wire [31:0] avs_writedata_i,
	output reg  [31:0] avs_readdata_o,
	output wire        avs_waitrequest_o,
	input  wire        port_a_chip_select_n_i,
	input  wire        port_a_enable_i,
	input  wire        port_a_write_read_sel_i,
	input  wire        port_a_mailbox_sel_i,
	input  wire        port_a_parity_generate_sel_i,
	input  wire [35:0] port_a_data_i,
	output reg  [35:0] port_a_data_o,
	output wire        port_a_data_oe_o,
	output wire        port_a_parity_error_n_o,
	input  wire        port_b_chip_select_n_i,
	input  wire        port_b_enable_i,
	input  wire        port_b_write_read_sel_i,
	input  wire        port_b_size_sel_lo_i,
	input  wire        port_b_size_sel_hi_i,
	input  wire        swap_mode_sel_lo_i,
	input  wire        swap_mode_sel_hi_i,
	input  wire        big_endian_sel_n_i,
	input  wire        port_b_parity_generate_sel_i,
	input  wire [35:0] port_b_data_i,
	output reg  [35:0] port_b_data_o,
	output wire        port_b_data_oe_o,
	output wire        port_b_parity_error_n_o,
	output wire        a_to_b_mailbox_full_o,
	output wire        b_to_a_mailbox_full_o,
	output wire        fifo_empty_o,
	output wire        fifo_full_o
);

	// Parity of one nine-bit byte from its low eight bits
	function par_bit;
		input [7:0] d;
		input       odd;
		begin
			par_bit = odd ? ~(^d) : (^d); // RL5 RL19
		end
	endfunction

	// Replace each byte's top bit with generated parity
	function [35:0] gen_par;
		input [35:0] w;
		input        odd;
		integer      i;
		begin
			gen_par = w;
			for (i = 0; i < 4; i = i + 1) begin
				gen_par[9*i+8] = par_bit(w[9*i +: 8], odd); // RL2 RL3 RL6
			end
		end
	endfunction

	// Flag byte whose stored parity does not match
	function par_bad;
		input [35:0] w;
		input        odd;
		integer      i;
		begin
			par_bad = 1'b0;
			for (i = 0; i < 4; i = i + 1) begin
				if (w[9*i+8] != par_bit(w[9*i +: 8], odd))
					par_bad = 1'b1;
			end
		end
	endfunction

	// Byte reordering of a long word A,B,C,D (A high)
	function [35:0] swap_word;
		input [35:0] w;
		input [1:0]  m;
		begin
			case (m)
				`FRP_SWAP_NONE:   swap_word = w;
				`FRP_SWAP_FULL:   swap_word = {w[8:0], w[17:9], w[26:18], w[35:27]};
				`FRP_SWAP_HALVES: swap_word = {w[17:9], w[8:0], w[35:27], w[26:18]};
				default:          swap_word = {w[26:18], w[35:27], w[8:0], w[17:9]};
			endcase
		end
	endfunction

	reg  [35:0] fifo_mem [0:63];
	reg  [5:0]  wr_ptr_reg;
	reg  [5:0]  rd_ptr_reg;
	reg  [6:0]  count_reg;
	reg  [35:0] a_to_b_mailbox_reg;
	reg  [35:0] b_to_a_mailbox_reg;
	reg         a_to_b_full_reg;
	reg         b_to_a_full_reg;
	reg  [35:0] hold_reg;
	reg  [1:0]  left_reg;
	reg  [1:0]  pos_reg;
	reg  [1:0]  size_reg;
	reg         be_n_reg;
	reg  [1:0]  swap_reg;
	reg         ctrl_odd_reg;
	reg         ack_reg;

	wire        odd_sel = ctrl_odd_reg;
	wire [1:0]  size_sel = {port_b_size_sel_hi_i, port_b_size_sel_lo_i};
	wire [1:0]  swap_sel = {swap_mode_sel_hi_i, swap_mode_sel_lo_i};
	wire        a_sel = ~port_a_chip_select_n_i & port_a_enable_i;
	wire        b_sel = ~port_b_chip_select_n_i & port_b_enable_i;
	wire        a_wr = a_sel & port_a_write_read_sel_i;
	wire        a_rd = a_sel & ~port_a_write_read_sel_i;
	wire        b_wr = b_sel & port_b_write_read_sel_i;
	wire        b_rd = b_sel & ~port_b_write_read_sel_i;
	wire        empty = (count_reg == 7'h00);
	wire        full = (count_reg == `FRP_FIFO_DEPTH);
	wire        b_mail = (size_sel == `FRP_SIZE_MAIL); // RL15
	wire        a_mail_rd = a_rd & port_a_mailbox_sel_i;
	wire        a_mail_gen = a_mail_rd & port_a_parity_generate_sel_i; // RL10
	wire        b_mail_rd = b_rd & b_mail;
	wire        b_mail_gen = b_mail_rd & port_b_parity_generate_sel_i; // RL10
	wire        push = a_wr & ~port_a_mailbox_sel_i & ~full;
	wire        a_mail_wr = a_wr & port_a_mailbox_sel_i & ~a_to_b_full_reg;
	wire        b_mail_wr = b_wr & b_mail & ~b_to_a_full_reg;
	wire        b_fifo_rd = b_rd & ~b_mail;
	wire        new_long = b_fifo_rd & ((left_reg == 2'd0) | (size_sel != size_reg));
	wire        pop = new_long & ~empty;
	wire        next_piece = b_fifo_rd & ~new_long;

	// Shared checker trees: port A bus or the B-to-A mailbox, port B bus or A-to-B mailbox
	wire [35:0] tree_a_in = a_mail_gen ? b_to_a_mailbox_reg : port_a_data_i; // RL9
	wire [35:0] tree_b_in = b_mail_gen ? a_to_b_mailbox_reg : port_b_data_i; // RL9
	wire [35:0] tree_a_out = gen_par(tree_a_in, odd_sel);
	wire [35:0] tree_b_out = gen_par(tree_b_in, odd_sel);

	// Parity and swap applied between memory and output register
	wire [35:0] fifo_word = fifo_mem[rd_ptr_reg];
	wire [35:0] fifo_par = port_b_parity_generate_sel_i ? gen_par(fifo_word, odd_sel)
		: fifo_word; // RL1 RL7 RL8
	wire [35:0] fifo_swapped = swap_word(fifo_par, swap_sel); // RL12 RL18

	// Pick the piece of a held long word for a given read number
	function [35:0] piece;
		input [35:0] w;
		input [1:0]  sz;
		input        be_n;
		input [1:0]  k;
		reg   [8:0]  byte_v;
		reg   [17:0] half_v;
		begin
			byte_v = w[9*(be_n ? k : 2'd3 - k) +: 9];
			half_v = (k[0] ^ be_n) ? w[17:0] : w[35:18];
			case (sz)
				`FRP_SIZE_WORD: piece = be_n ? {18'h0_0000, half_v}
					: {half_v, 18'h0_0000}; // RL13 RL14
				`FRP_SIZE_BYTE: piece = be_n ? {27'h000_0000, byte_v}
					: {byte_v, 27'h000_0000}; // RL16 RL14
				default:        piece = w;
			endcase
		end
	endfunction

	always @(posedge ref_clk_i) begin
		if (push) begin
			fifo_mem[wr_ptr_reg] <= port_a_data_i; // RL4
		end
	end

	always @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			wr_ptr_reg <= 6'h00;
			rd_ptr_reg <= 6'h00;
			count_reg <= 7'h00;
			a_to_b_mailbox_reg <= `FRP_WORD_ZERO;
			b_to_a_mailbox_reg <= `FRP_WORD_ZERO;
			a_to_b_full_reg <= 1'b0;
			b_to_a_full_reg <= 1'b0;
			hold_reg <= `FRP_WORD_ZERO;
			left_reg <= 2'd0;
			pos_reg <= 2'd0;
			size_reg <= `FRP_SIZE_LONG;
			be_n_reg <= 1'b1;
			swap_reg <= `FRP_SWAP_NONE;
			port_a_data_o <= `FRP_WORD_ZERO;
			port_b_data_o <= `FRP_WORD_ZERO;
		end else begin
			if (push)
				wr_ptr_reg <= wr_ptr_reg + 6'h01;
			if (pop)
				rd_ptr_reg <= rd_ptr_reg + 6'h01;
			if (push & ~pop)
				count_reg <= count_reg + 7'h01;
			else if (pop & ~push)
				count_reg <= count_reg - 7'h01;
			if (a_mail_wr)
				a_to_b_mailbox_reg <= port_a_data_i; // RL4
			if (b_mail_wr)
				b_to_a_mailbox_reg <= port_b_data_i; // RL4
			// Write only lands while flag clear; a mailbox read in the same cycle loses to the set
			if (a_mail_wr)
				a_to_b_full_reg <= 1'b1;
			else if (b_mail_rd)
				a_to_b_full_reg <= 1'b0;
			if (b_mail_wr)
				b_to_a_full_reg <= 1'b1;
			else if (a_mail_rd)
				b_to_a_full_reg <= 1'b0;
			if (a_mail_rd)
				port_a_data_o <= a_mail_gen ? tree_a_out : b_to_a_mailbox_reg; // RL11
			if (b_mail_rd) begin
				port_b_data_o <= b_mail_gen ? tree_b_out : a_to_b_mailbox_reg; // RL15 RL11
			end else if (pop) begin
				hold_reg <= fifo_swapped; // RL17
				swap_reg <= swap_sel; // RL17
				size_reg <= size_sel;
				be_n_reg <= big_endian_sel_n_i;
				pos_reg <= 2'd1;
				case (size_sel)
					`FRP_SIZE_WORD: left_reg <= 2'd1;
					`FRP_SIZE_BYTE: left_reg <= 2'd3;
					default:        left_reg <= 2'd0;
				endcase
				port_b_data_o <= piece(fifo_swapped, size_sel, big_endian_sel_n_i,
					2'd0); // RL7 RL18
			end else if (next_piece) begin
				port_b_data_o <= piece(hold_reg, size_reg, be_n_reg, pos_reg); // RL17
				pos_reg <= pos_reg + 2'd1;
				left_reg <= left_reg - 2'd1;
			end
		end
	end

	// Register bus: one wait cycle; a write lands on the edge after the one that ends the wait
	always @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			ctrl_odd_reg <= `FRP_CTRL_RESET;
			avs_readdata_o <= `FRP_BUS_ZERO;
		end else begin
			ack_reg <= (avs_read_i | avs_write_i) & ~ack_reg;
			if (avs_write_i & ack_reg & (avs_address_i == `FRP_ADDR_CTRL))
				ctrl_odd_reg <= avs_writedata_i[`FRP_CTRL_ODD_BIT];
			if (avs_read_i & ~ack_reg) begin
				case (avs_address_i)
					`FRP_ADDR_CTRL:   avs_readdata_o <= {31'h0000_0000, ctrl_odd_reg};
					`FRP_ADDR_STATUS: avs_readdata_o <= {24'h00_0000, left_reg, swap_reg,
						full, empty, b_to_a_full_reg, a_to_b_full_reg};
					default:          avs_readdata_o <= `FRP_BUS_ZERO;
				endcase
			end
		end
	end

	assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_reg;
	assign port_a_data_oe_o = a_rd;
	assign port_b_data_oe_o = b_rd;
	// Checker flag forced high while its trees generate mailbox parity
	assign port_a_parity_error_n_o = a_mail_gen | ~par_bad(port_a_data_i, odd_sel); // RL9
	assign port_b_parity_error_n_o = b_mail_gen | ~par_bad(port_b_data_i, odd_sel); // RL9
	assign a_to_b_mailbox_full_o = a_to_b_full_reg;
	assign b_to_a_mailbox_full_o = b_to_a_full_reg;
	assign fifo_empty_o = empty;
	assign fifo_full_o = full;

endmodule
`default_nettype wire

// >>> frp_defs.vh
// Constants for the read-path parity, swap and bus-sizing block
// What this block does
// RL1: Parity-generate select high generates parity on reads
// RL2: Port A bytes are nine bits, top parity
// RL3: Port B bytes are nine bits, top parity
// RL4: Writes store all nine bits unchanged
// RL5: Parity from low eight bits, odd/even polarity
// RL6: Generated parity replaces stored top bit
// RL7: FIFO parity inserted before output register
// RL8: Selects take effect on new long-word load
// RL9: Mailbox parity reuses the reading port's checker trees
// RL10: Mailbox parity only on selected mailbox read
// RL11: Mailbox contents unchanged by parity generation
// RL12: Swap modes ABCD, DCBA, CDAB, BADC
// RL13: Word reads ordered by endian, two per long word
// RL14: Unused lanes indeterminate on narrow reads
// RL15: Both size selects high output mailbox
// RL16: Byte reads ordered by endian, four per long word
// RL17: Swap mode held through whole long word
// RL18: Swap first, then sequence by bus size
// RL19: Odd gives odd ones count, even even
`ifndef FRP_DEFS_VH
`define FRP_DEFS_VH
`define FRP_ADDR_CTRL      4'h0
`define FRP_ADDR_STATUS    4'h4
`define FRP_CTRL_ODD_BIT   0
`define FRP_CTRL_RESET     1'b0
`define FRP_SIZE_LONG      2'b00
`define FRP_SIZE_WORD      2'b01
`define FRP_SIZE_BYTE      2'b10
`define FRP_SIZE_MAIL      2'b11
`define FRP_SWAP_NONE      2'b00
`define FRP_SWAP_FULL      2'b01
`define FRP_SWAP_HALVES    2'b10
`define FRP_SWAP_PAIRS     2'b11
`define FRP_FIFO_DEPTH     7'h40
`define FRP_WORD_ZERO      36'h0_0000_0000
`define FRP_BUS_ZERO       32'h0000_0000
`endif

// >>> frp_read_path_props.sv
// Concurrent checks on the read-path block ports
`default_nettype none
module frp_read_path_props (
	input wire logic        ref_clk_i,
	input wire logic        rst_i,
	input wire logic        avs_read_i,
	input wire logic        avs_write_i,
	input wire logic        avs_waitrequest_o,
	input wire logic        port_a_chip_select_n_i,
	input wire logic        port_a_enable_i,
	input wire logic        port_a_write_read_sel_i,
	input wire logic        port_a_mailbox_sel_i,
	input wire logic        port_a_parity_generate_sel_i,
	input wire logic [35:0] port_a_data_o,
	input wire logic        port_a_data_oe_o,
	input wire logic        port_a_parity_error_n_o,
	input wire logic        port_b_chip_select_n_i,
	input wire logic        port_b_enable_i,
	input wire logic        port_b_write_read_sel_i,
	input wire logic        port_b_size_sel_lo_i,
	input wire logic        port_b_size_sel_hi_i,
	input wire logic        port_b_parity_generate_sel_i,
	input wire logic [35:0] port_b_data_o,
	input wire logic        port_b_data_oe_o,
	input wire logic        port_b_parity_error_n_o,
	input wire logic        a_to_b_mailbox_full_o,
	input wire logic        fifo_empty_o
);
	wire rd_a = !port_a_chip_select_n_i && port_a_enable_i && !port_a_write_read_sel_i;
	wire rd_b = !port_b_chip_select_n_i && port_b_enable_i && !port_b_write_read_sel_i;
	wire mb_b = rd_b && port_b_size_sel_lo_i && port_b_size_sel_hi_i;
	wire wr_a = !port_a_chip_select_n_i && port_a_enable_i && port_a_write_read_sel_i;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	chk_wait_ack: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o) else $error("waitrequest not dropped");
	chk_oe_a: assert property (port_a_data_oe_o == rd_a) else $error("port A enable wrong");
	chk_oe_b: assert property (port_b_data_oe_o == rd_b) else $error("port B enable wrong");
	chk_pefa_held: assert property (rd_a && port_a_mailbox_sel_i && port_a_parity_generate_sel_i |-> port_a_parity_error_n_o) else $error("port A error flag not held");
	chk_pefb_held: assert property (mb_b && port_b_parity_generate_sel_i |-> port_b_parity_error_n_o) else $error("port B error flag not held");
	chk_par_a: assert property (rd_a && port_a_mailbox_sel_i && port_a_parity_generate_sel_i |=> (^port_a_data_o[8:0] == ^port_a_data_o[17:9]) && (^port_a_data_o[26:18] == ^port_a_data_o[35:27]) && (^port_a_data_o[8:0] == ^port_a_data_o[35:27])) else $error("port A byte parity mixed");
	chk_par_b: assert property (mb_b && port_b_parity_generate_sel_i |=> (^port_b_data_o[8:0] == ^port_b_data_o[17:9]) && (^port_b_data_o[26:18] == ^port_b_data_o[35:27]) && (^port_b_data_o[8:0] == ^port_b_data_o[35:27])) else $error("port B byte parity mixed");
	chk_mbx_flag: assert property (mb_b && !(wr_a && port_a_mailbox_sel_i) |=> !a_to_b_mailbox_full_o) else $error("mailbox flag kept");
	chk_fifo_kept: assert property (mb_b && !wr_a |=> $stable(fifo_empty_o)) else $error("mailbox read touched fifo");
endmodule
bind frp_read_path frp_read_path_props frp_read_path_props_inst (.ref_clk_i, .rst_i,
	.avs_read_i, .avs_write_i, .avs_waitrequest_o, .port_a_chip_select_n_i, .port_a_enable_i,
	.port_a_write_read_sel_i, .port_a_mailbox_sel_i, .port_a_parity_generate_sel_i,
	.port_a_data_o, .port_a_data_oe_o, .port_a_parity_error_n_o, .port_b_chip_select_n_i,
	.port_b_enable_i, .port_b_write_read_sel_i, .port_b_size_sel_lo_i, .port_b_size_sel_hi_i,
	.port_b_parity_generate_sel_i, .port_b_data_o, .port_b_data_oe_o,
	.port_b_parity_error_n_o, .a_to_b_mailbox_full_o, .fifo_empty_o);
`default_nettype wire

// >>> frp_host_model.sv
// Port A bus master model: FIFO and mailbox writes, mailbox reads
`default_nettype none
module frp_host_model (
	input  wire logic        clk_i,
	input  wire logic [35:0] rd_i,
	output wire logic        cs_n_o,
	output wire logic        en_o,
	output wire logic        wr_o,
	output wire logic        mbx_o,
	output wire logic        pg_o,
	output var  logic [35:0] data_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [4:0] c = 5'h10;
	assign {cs_n_o, en_o, wr_o, mbx_o, pg_o} = c;
	initial data_o = 36'h0_0000_0000;
	// All nine bits of each byte applied as given
	task automatic put(input logic mbx, input logic [35:0] d);
		@(posedge clk_i);
		c <= {3'h3, mbx, 1'h0};
		data_o <= d;
		@(posedge clk_i);
		c <= 5'h10;
		data_o <= ~d;
	endtask
	task automatic get(input logic pg, output logic [35:0] q);
		@(posedge clk_i);
		c <= {3'h2, 1'h1, pg};
		@(posedge clk_i);
		c <= 5'h10;
		@(negedge clk_i);
		q = rd_i;
	endtask
endmodule
`default_nettype wire

// >>> frp_read_path_tb.sv
// Self-checking bench for the read-path block
`default_nettype none
module frp_read_path_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        ref_clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        av_rd = 1'b0;
	logic        av_wr = 1'b0;
	logic [3:0]  av_a = 4'h0;
	logic [31:0] av_d = 32'h0000_0000;
	logic [31:0] q32;
	logic [8:0]  bc = 9'h100;
	logic [35:0] bd = 36'h0_0000_0000;
	logic [35:0] q, s, qa;
	logic [35:0] w = 36'hf_1234_5678;
	wire         a_cs_n, a_en, a_wr, a_mbx, a_pg, wq;
	wire  [35:0] a_d, a_q, b_q;
	int          err_total = 0;
	int          n_checks = 0;
	always #2 ref_clk_i = ~ref_clk_i;
	frp_host_model frp_host_model_inst (.clk_i(ref_clk_i), .rd_i(a_q), .cs_n_o(a_cs_n),
		.en_o(a_en), .wr_o(a_wr), .mbx_o(a_mbx), .pg_o(a_pg), .data_o(a_d));
	frp_read_path frp_read_path_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
		.avs_address_i(av_a), .avs_read_i(av_rd), .avs_write_i(av_wr), .avs_writedata_i(av_d),
		.avs_readdata_o(q32), .avs_waitrequest_o(wq), .port_a_chip_select_n_i(a_cs_n),
		.port_a_enable_i(a_en), .port_a_write_read_sel_i(a_wr), .port_a_mailbox_sel_i(a_mbx),
		.port_a_parity_generate_sel_i(a_pg), .port_a_data_i(a_d), .port_a_data_o(a_q),
		.port_a_data_oe_o(), .port_a_parity_error_n_o(), .port_b_chip_select_n_i(bc[8]),
		.port_b_enable_i(bc[7]), .port_b_write_read_sel_i(bc[6]), .port_b_size_sel_hi_i(bc[5]),
		.port_b_size_sel_lo_i(bc[4]), .swap_mode_sel_hi_i(bc[3]), .swap_mode_sel_lo_i(bc[2]),
		.big_endian_sel_n_i(bc[1]), .port_b_parity_generate_sel_i(bc[0]), .port_b_data_i(bd),
		.port_b_data_o(b_q), .port_b_data_oe_o(), .port_b_parity_error_n_o(),
		.a_to_b_mailbox_full_o(), .b_to_a_mailbox_full_o(), .fifo_empty_o(), .fifo_full_o());
	function automatic logic [35:0] gen(input logic [35:0] v, input logic odd);
		for (int k = 0; k < 4; k++) v[9*k+8] = (^v[9*k+:8]) ^ odd;
		return v;
	endfunction
	function automatic logic [35:0] swp(input logic [35:0] v, input logic [1:0] m);
		case (m)
			2'h1: return {v[8:0], v[17:9], v[26:18], v[35:27]};
			2'h2: return {v[17:0], v[35:18]};
			2'h3: return {v[26:18], v[35:27], v[8:0], v[17:9]};
			default: return v;
		endcase
	endfunction
	task automatic chk(input logic [35:0] got, input logic [35:0] exp);
		n_checks++;
		if (got !== exp) begin
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			err_total++;
		end
	endtask
	task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int n;
		@(posedge ref_clk_i);
		{av_rd, av_wr, av_a, av_d} <= {!wr, wr, a, d};
		n = 0;
		do begin
			@(posedge ref_clk_i);
			n++;
		end while (wq !== 1'b0 && n < 50);
		if (n >= 50) begin
			$display("BAD t=%0t got=%h exp=%h", $time, 1'b1, 1'b0);
			err_total++;
		end
		{av_rd, av_wr} <= 2'h0;
	endtask
	// Port B access: {cs_n, en, wr, size, swap, be_n, pg}
	task automatic pb(input logic wr, input logic [1:0] sz, input logic [1:0] sm,
		input logic bn, input logic pg, input logic [35:0] d);
		@(posedge ref_clk_i);
		bc <= {2'h1, wr, sz, sm, bn, pg};
		bd <= d;
		@(posedge ref_clk_i);
		bc <= 9'h100;
		bd <= ~d;
		@(negedge ref_clk_i);
		q = b_q;
	endtask
	task automatic end_sim;
		$display("checks=%0d errors=%0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		#20000;
		err_total++;
		end_sim();
	end
	initial begin
		repeat (2) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		av(1'b1, 4'h0, 32'h0000_0001);
		av(1'b0, 4'h0, 32'h0000_0000);
		chk(36'(q32), 36'h0_0000_0001);
		av(1'b0, 4'h8, 32'h0000_0000);
		chk(36'(q32), 36'h0_0000_0000);
		frp_host_model_inst.put(1'b0, w);
		pb(1'b0, 2'h0, 2'h0, 1'b0, 1'b1, w);
		chk(q, gen(w, 1'b1));
		av(1'b1, 4'h0, 32'h0000_0000);
		frp_host_model_inst.put(1'b0, w);
		pb(1'b0, 2'h0, 2'h0, 1'b0, 1'b1, w);
		chk(q, gen(w, 1'b0));
		for (int m = 0; m < 4; m++) begin
			frp_host_model_inst.put(1'b0, w);
			pb(1'b0, 2'h0, m[1:0], 1'b0, 1'b0, w);
			chk(q, swp(w, m[1:0]));
		end
		for (int e = 0; e < 2; e++) begin
			s = swp(w, e ? 2'h3 : 2'h2);
			frp_host_model_inst.put(1'b0, w);
			pb(1'b0, 2'h1, e ? 2'h3 : 2'h2, e[0], 1'b0, w);
			chk(36'(e ? q[17:0] : q[35:18]), 36'(e ? s[17:0] : s[35:18]));
			pb(1'b0, 2'h1, 2'h1, e[0], 1'b0, w);
			chk(36'(e ? q[17:0] : q[35:18]), 36'(e ? s[35:18] : s[17:0]));
			s = swp(w, e ? 2'h0 : 2'h1);
			frp_host_model_inst.put(1'b0, w);
			for (int i = 0; i < 4; i++) begin
				pb(1'b0, 2'h2, e ? 2'h0 : 2'h1, e[0], 1'b0, w);
				chk(36'(e ? q[8:0] : q[35:27]), 36'(e ? s[9*i+:9] : s[35-9*i-:9]));
			end
		end
		frp_host_model_inst.put(1'b1, w);
		pb(1'b0, 2'h3, 2'h1, 1'b0, 1'b1, w);
		chk(q, gen(w, 1'b0));
		pb(1'b0, 2'h3, 2'h0, 1'b0, 1'b0, w);
		chk(q, w);
		pb(1'b1, 2'h3, 2'h0, 1'b0, 1'b0, 36'h0_8421_fedc);
		frp_host_model_inst.get(1'b1, qa);
		chk(qa, gen(36'h0_8421_fedc, 1'b0));
		end_sim();
	end
endmodule
`default_nettype wire
